// ---- rtl/pmc_pkg.sv ----
// Package with the register map, field layout, modes and timing of the power mode controller.
package pmc_pkg;

    // ****************************************************************
    // Register bus
    // ****************************************************************
    localparam int unsigned ADDR_W = 4;
    localparam int unsigned DATA_W = 16;

    typedef struct packed {
        logic              wr;
        logic              rd;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } pmc_bus_req_s;

    localparam logic [ADDR_W-1:0] OFS_PLL_CTRL   = 4'h0;
    localparam logic [ADDR_W-1:0] OFS_REG_CTRL   = 4'h1;
    localparam logic [ADDR_W-1:0] OFS_MODE_GO    = 4'h2;
    localparam logic [ADDR_W-1:0] OFS_PERIPH_CLK = 4'h3;
    localparam logic [ADDR_W-1:0] OFS_STATUS     = 4'h4;

    // ****************************************************************
    // Field layout
    // ****************************************************************
    localparam int unsigned PC_PLL_OFF = 0;
    localparam int unsigned PC_BYPASS  = 1;
    localparam int unsigned PC_SLEEP   = 2;
    localparam int unsigned PC_DEEP    = 3;
    localparam int unsigned PC_MULT_LO = 4;
    localparam int unsigned MULT_W     = 6;
    localparam int unsigned PC_W       = PC_MULT_LO + MULT_W;

    localparam int unsigned RC_REGULATOR_FREQUENCY_FIELD_LO = 0;
    localparam int unsigned REGULATOR_FREQUENCY_FIELD_W     = 2;
    localparam int unsigned RC_VSEL_LO = 4;
    localparam int unsigned VSEL_W     = 4;
    localparam int unsigned RC_WAKE_LO = 8;
    localparam int unsigned WAKE_EN_W  = 3;
    localparam int unsigned RC_W       = RC_WAKE_LO + WAKE_EN_W;

    localparam int unsigned ST_MODE_LO = 0;
    localparam int unsigned ST_BUSY    = 5;
    localparam int unsigned ST_MULT_LO = 6;

    // ****************************************************************
    // Reset values
    // ****************************************************************
    localparam logic [PC_W-1:0]     PLL_CTRL_RST   = 10'h0A0;
    localparam logic [REGULATOR_FREQUENCY_FIELD_W-1:0]   REGULATOR_FREQUENCY_FIELD_RST       = 2'h3;
    localparam logic [REGULATOR_FREQUENCY_FIELD_W-1:0]   REGULATOR_FREQUENCY_FIELD_OFF       = 2'h0;
    localparam logic [VSEL_W-1:0]   VSEL_RST       = 4'h8;
    localparam logic [WAKE_EN_W-1:0] WAKE_EN_RST   = 3'h7;
    localparam logic [DATA_W-1:0]   PERIPH_CLK_RST = 16'hFFFF;
    localparam logic [MULT_W-1:0]   MULT_RST       = 6'h0A;

    // ****************************************************************
    // Modes, wake inputs and control outputs
    // ****************************************************************
    typedef enum logic [4:0] {
        MODE_FULL_ON = 5'h01,
        MODE_ACTIVE  = 5'h02,
        MODE_SLEEP   = 5'h04,
        MODE_DEEP    = 5'h08,
        MODE_HIBER   = 5'h10
    } pmc_mode_e;

    localparam int unsigned WAKE_W = 5;

    typedef struct packed {
        logic pll_enable;
        logic pll_bypass;
        logic core_clk_en;
        logic sys_clk_en;
        logic core_power;
        logic l1_dma_allow;
    } pmc_ctl_s;

    // ****************************************************************
    // Timing
    // ****************************************************************
    localparam int unsigned CLK_NS    = 20;
    localparam int unsigned SETTLE_NS = 200;
    localparam int unsigned CNT_W     = 4;
    localparam logic [CNT_W-1:0] SETTLE_CYC =
        CNT_W'((SETTLE_NS + CLK_NS - 1) / CLK_NS);

endpackage

// ---- rtl/pmc_sync.sv ----
// Two-flop synchroniser for a group of asynchronous wake inputs.
module pmc_sync #(
    parameter int unsigned W = pmc_pkg::WAKE_W
) (
    input  wire logic         ref_clk,
    input  wire logic         rstn,
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] dout
);

    logic [W-1:0] meta;

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            meta <= '0;
            dout <= '0;
        end else begin
            meta <= din;
            dout <= meta;
        end
    end

endmodule

// ---- rtl/pmc_power_mode_controller.sv ----
// Top module of the power mode controller: mode machine, clock sequencing and registers.

// Overview of operation
// - Five one-hot modes; exactly one is held at any time.
// - Full-on: PLL enabled and not bypassed, clocks at full rate.
// - Reset leaves the controller in full-on.
// - Active: PLL enabled but bypassed, clocks at input clock rate.
// - Multiplier written in active applies only on next full-on entry.
// - Level-one DMA stays allowed in active mode.
// - Software may switch the PLL off while in active mode.
// - Sleep: core clock stopped, PLL and system clock keep running.
// - Sleep wake goes to full-on when bypass clear, active when set.
// - Level-one DMA is refused while in sleep.
// - External event or real-time-clock activity ends sleep.
// - Each peripheral clock has its own gate enable.
// - Core supply voltage level is changeable at run time.
// - Transceiver wake preamble or interrupt wakes from sleep.
// - Transceiver network activity wakes sleep or hibernate and restores regulator.
// - Deep sleep stops both clocks; clock alarm to active, reset to full-on.
// - Regulator frequency field written zero enters hibernate, power removed.
module pmc_power_mode_controller (
    input  wire logic                          ref_clk,
    input  wire logic                          rstn,
    input  wire pmc_pkg::pmc_bus_req_s         bus,
    output logic     [pmc_pkg::DATA_W-1:0]     rdata,
    input  wire logic                          ext_wake,
    input  wire logic                          rtc_wake,
    input  wire logic                          xcvr_preamble,
    input  wire logic                          xcvr_irq,
    input  wire logic                          xcvr_activity,
    output pmc_pkg::pmc_ctl_s                  ctl,
    output logic     [pmc_pkg::MULT_W-1:0]     core_mult,
    output logic     [pmc_pkg::VSEL_W-1:0]     core_voltage_sel,
    output logic     [pmc_pkg::DATA_W-1:0]     periph_clk_en,
    output pmc_pkg::pmc_mode_e                 mode
);

    // ****************************************************************
    // Sequencer states and signals
    // ****************************************************************
    typedef enum logic [2:0] {
        SEQ_IDLE   = 3'h1,
        SEQ_GATE   = 3'h2,
        SEQ_SWITCH = 3'h4
    } pmc_seq_e;

    pmc_seq_e                        seq;
    pmc_seq_e                        next_seq;
    logic [pmc_pkg::CNT_W-1:0]       cnt;
    logic [pmc_pkg::CNT_W-1:0]       next_cnt;
    logic [pmc_pkg::PC_W-1:0]        pll_ctrl;
    logic [pmc_pkg::PC_W-1:0]        next_pll_ctrl;
    logic [pmc_pkg::REGULATOR_FREQUENCY_FIELD_W-1:0]      regulator_frequency_field;
    logic [pmc_pkg::REGULATOR_FREQUENCY_FIELD_W-1:0]      next_regulator_frequency_field;
    logic [pmc_pkg::WAKE_EN_W-1:0]   wake_en;
    logic [pmc_pkg::WAKE_W-1:0]      wake_sync;
    pmc_pkg::pmc_mode_e              req_mode;
    logic                            req_valid;
    pmc_pkg::pmc_ctl_s               tgt;
    pmc_pkg::pmc_ctl_s               next_ctl;
    logic [pmc_pkg::DATA_W-1:0]      rd_mux;

    // Target control outputs of a mode once its sequence has completed.
    function automatic pmc_pkg::pmc_ctl_s f_target(pmc_pkg::pmc_mode_e m, logic byp,
                                                   logic pll_off);
        pmc_pkg::pmc_ctl_s t;
        t = '0;
        t.pll_bypass = byp;
        case (m)
            pmc_pkg::MODE_FULL_ON: begin
                t = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1};
            end
            pmc_pkg::MODE_ACTIVE: begin
                t = '{~pll_off, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1};
            end
            pmc_pkg::MODE_SLEEP: begin
                t = '{1'b1, byp, 1'b0, 1'b1, 1'b1, 1'b0};
            end
            pmc_pkg::MODE_DEEP: begin
                t = '{1'b0, byp, 1'b0, 1'b0, 1'b1, 1'b0};
            end
            pmc_pkg::MODE_HIBER: begin
                t = '{1'b0, byp, 1'b0, 1'b0, 1'b0, 1'b0};
            end
            default: begin
                t = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1};
            end
        endcase
        return t;
    endfunction

    // Decodes a register strobe at one offset.
    function automatic logic f_hit(logic strobe, logic [pmc_pkg::ADDR_W-1:0] a,
                                   logic [pmc_pkg::ADDR_W-1:0] ofs);
        return strobe && (a == ofs);
    endfunction

    // ****************************************************************
    // Wake input synchronisation
    // ****************************************************************
    pmc_sync #(
        .W (pmc_pkg::WAKE_W)
    ) u_wake_sync (
        .ref_clk (ref_clk),
        .rstn    (rstn),
        .din     ({xcvr_activity, xcvr_irq, xcvr_preamble, rtc_wake, ext_wake}),
        .dout    (wake_sync)
    );

    wire s_ext      = wake_sync[0];
    wire s_rtc      = wake_sync[1];
    wire s_pre      = wake_sync[2];
    wire s_irq      = wake_sync[3];
    wire s_act      = wake_sync[4];
    wire wake_sleep = s_ext | s_rtc | s_pre | s_irq | s_act;
    wire wake_hiber = (s_ext & wake_en[2]) | (s_rtc & wake_en[1])
                    | (s_act & wake_en[0]);

    // ****************************************************************
    // Register decode
    // ****************************************************************
    wire wr_pll   = f_hit(bus.wr, bus.addr, pmc_pkg::OFS_PLL_CTRL);
    wire wr_reg   = f_hit(bus.wr, bus.addr, pmc_pkg::OFS_REG_CTRL);
    wire wr_go    = f_hit(bus.wr, bus.addr, pmc_pkg::OFS_MODE_GO);
    wire wr_pclk  = f_hit(bus.wr, bus.addr, pmc_pkg::OFS_PERIPH_CLK);
    wire byp_bit  = pll_ctrl[pmc_pkg::PC_BYPASS];
    wire off_bit  = pll_ctrl[pmc_pkg::PC_PLL_OFF];
    wire slp_bit  = pll_ctrl[pmc_pkg::PC_SLEEP];
    wire deep_bit = pll_ctrl[pmc_pkg::PC_DEEP];
    wire busy     = (seq != SEQ_IDLE);
    wire run_mode = (mode == pmc_pkg::MODE_FULL_ON) || (mode == pmc_pkg::MODE_ACTIVE);
    wire cnt_done = (cnt == '0);
    wire pll_chg  = (ctl.pll_enable != tgt.pll_enable) || (ctl.pll_bypass != tgt.pll_bypass);
    wire hib_exit = req_valid && (mode == pmc_pkg::MODE_HIBER);

    // ****************************************************************
    // Mode request selection
    // ****************************************************************
    always_comb begin
        req_valid = 1'b0;
        req_mode  = mode;
        if (!busy) begin
            case (mode)
                pmc_pkg::MODE_FULL_ON, pmc_pkg::MODE_ACTIVE: begin
                    if (regulator_frequency_field == pmc_pkg::REGULATOR_FREQUENCY_FIELD_OFF) begin
                        req_valid = 1'b1;
                        req_mode  = pmc_pkg::MODE_HIBER;
                    end else if (wr_go) begin
                        req_valid = 1'b1;
                        if (slp_bit) begin
                            req_mode = pmc_pkg::MODE_SLEEP;
                        end else if (deep_bit) begin
                            req_mode = pmc_pkg::MODE_DEEP;
                        end else if (byp_bit) begin
                            req_mode = pmc_pkg::MODE_ACTIVE;
                        end else begin
                            req_mode = pmc_pkg::MODE_FULL_ON;
                        end
                    end
                end
                pmc_pkg::MODE_SLEEP: begin
                    if (wake_sleep) begin
                        req_valid = 1'b1;
                        req_mode  = byp_bit ? pmc_pkg::MODE_ACTIVE
                                            : pmc_pkg::MODE_FULL_ON;
                    end
                end
                pmc_pkg::MODE_DEEP: begin
                    if (s_rtc) begin
                        req_valid = 1'b1;
                        req_mode  = pmc_pkg::MODE_ACTIVE;
                    end
                end
                pmc_pkg::MODE_HIBER: begin
                    if (wake_hiber) begin
                        req_valid = 1'b1;
                        req_mode  = pmc_pkg::MODE_FULL_ON;
                    end
                end
                default: begin
                    req_valid = 1'b1;
                    req_mode  = pmc_pkg::MODE_FULL_ON;
                end
            endcase
        end
    end

    assign tgt = f_target(mode, byp_bit, off_bit);

    // ****************************************************************
    // Clock and power sequencing
    // ****************************************************************
    // Clocks are narrowed first, PLL and power change only while clocks that must
    // stop are stopped, and clocks widen last, so no truncated pulse escapes.
    always_comb begin
        next_seq = seq;
        next_cnt = busy && !cnt_done ? cnt - 1'b1 : cnt;
        next_ctl = ctl;
        case (seq)
            SEQ_IDLE: begin
                if (req_valid) begin
                    next_seq = SEQ_GATE;
                    next_cnt = pmc_pkg::SETTLE_CYC;
                end
            end
            SEQ_GATE: begin
                next_ctl.core_clk_en  = ctl.core_clk_en & tgt.core_clk_en & ~pll_chg;
                next_ctl.sys_clk_en   = ctl.sys_clk_en & tgt.sys_clk_en & ~pll_chg;
                next_ctl.l1_dma_allow = ctl.l1_dma_allow & tgt.l1_dma_allow;
                if (cnt_done) begin
                    next_seq = SEQ_SWITCH;
                    next_cnt = pmc_pkg::SETTLE_CYC;
                    next_ctl.pll_enable = tgt.pll_enable;
                    next_ctl.pll_bypass = tgt.pll_bypass;
                    next_ctl.core_power = tgt.core_power;
                end
            end
            SEQ_SWITCH: begin
                if (cnt_done) begin
                    next_seq = SEQ_IDLE;
                    next_ctl = tgt;
                end
            end
            default: begin
                next_seq = SEQ_IDLE;
            end
        endcase
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            seq  <= SEQ_IDLE;
            cnt  <= '0;
            mode <= pmc_pkg::MODE_FULL_ON;
            ctl  <= '{1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1};
        end else begin
            seq  <= next_seq;
            cnt  <= next_cnt;
            mode <= req_valid ? req_mode : mode;
            ctl  <= next_ctl;
        end
    end

    // Multiplier reaches the clocks only when full-on is entered.
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            core_mult <= pmc_pkg::MULT_RST;
        end else if (req_valid && req_mode == pmc_pkg::MODE_FULL_ON) begin
            core_mult <= pll_ctrl[pmc_pkg::PC_MULT_LO +: pmc_pkg::MULT_W];
        end
    end

    // ****************************************************************
    // Registers
    // ****************************************************************
    // Hibernate exit is a reset sequence: the PLL control register returns to defaults, core_mult takes the
    // multiplier held before the exit, and the regulator is switched back on.
    always_comb begin
        next_pll_ctrl = pll_ctrl;
        next_regulator_frequency_field     = regulator_frequency_field;
        if (hib_exit) begin
            next_pll_ctrl = pmc_pkg::PLL_CTRL_RST;
            next_regulator_frequency_field     = pmc_pkg::REGULATOR_FREQUENCY_FIELD_RST;
        end else begin
            if (wr_pll) begin
                next_pll_ctrl = bus.wdata[pmc_pkg::PC_W-1:0];
            end
            if (wr_reg) begin
                next_regulator_frequency_field = bus.wdata[pmc_pkg::RC_REGULATOR_FREQUENCY_FIELD_LO +: pmc_pkg::REGULATOR_FREQUENCY_FIELD_W];
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            pll_ctrl <= pmc_pkg::PLL_CTRL_RST;
            regulator_frequency_field     <= pmc_pkg::REGULATOR_FREQUENCY_FIELD_RST;
        end else begin
            pll_ctrl <= next_pll_ctrl;
            regulator_frequency_field     <= next_regulator_frequency_field;
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            core_voltage_sel <= pmc_pkg::VSEL_RST;
            wake_en          <= pmc_pkg::WAKE_EN_RST;
        end else if (wr_reg) begin
            core_voltage_sel <= bus.wdata[pmc_pkg::RC_VSEL_LO +: pmc_pkg::VSEL_W];
            wake_en          <= bus.wdata[pmc_pkg::RC_WAKE_LO +: pmc_pkg::WAKE_EN_W];
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            periph_clk_en <= pmc_pkg::PERIPH_CLK_RST;
        end else if (wr_pclk) begin
            periph_clk_en <= bus.wdata;
        end
    end

    // ****************************************************************
    // Read path
    // ****************************************************************
    always_comb begin
        rd_mux = '0;
        case (bus.addr)
            pmc_pkg::OFS_PLL_CTRL: begin
                rd_mux[pmc_pkg::PC_W-1:0] = pll_ctrl;
            end
            pmc_pkg::OFS_REG_CTRL: begin
                rd_mux[pmc_pkg::RC_REGULATOR_FREQUENCY_FIELD_LO +: pmc_pkg::REGULATOR_FREQUENCY_FIELD_W]    = regulator_frequency_field;
                rd_mux[pmc_pkg::RC_VSEL_LO +: pmc_pkg::VSEL_W]    = core_voltage_sel;
                rd_mux[pmc_pkg::RC_WAKE_LO +: pmc_pkg::WAKE_EN_W] = wake_en;
            end
            pmc_pkg::OFS_PERIPH_CLK: begin
                rd_mux = periph_clk_en;
            end
            pmc_pkg::OFS_STATUS: begin
                rd_mux[pmc_pkg::ST_MODE_LO +: 5]              = mode;
                rd_mux[pmc_pkg::ST_BUSY]                      = busy;
                rd_mux[pmc_pkg::ST_MULT_LO +: pmc_pkg::MULT_W] = core_mult;
            end
            default: begin
                rd_mux = '0;
            end
        endcase
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            rdata <= '0;
        end else begin
            rdata <= bus.rd ? rd_mux : '0;
        end
    end

    // ****************************************************************
    // Assertions
    // ****************************************************************
    chk_mode_onehot: assert property (@(posedge ref_clk) disable iff (!rstn)
        $onehot(mode))
        else $error("mode is not one-hot");

    chk_full_on_pll: assert property (@(posedge ref_clk) disable iff (!rstn)
        (mode == pmc_pkg::MODE_FULL_ON && !busy) |->
            (ctl.pll_enable && !ctl.pll_bypass && ctl.core_clk_en && ctl.sys_clk_en))
        else $error("full-on outputs wrong");

    chk_active_bypass: assert property (@(posedge ref_clk) disable iff (!rstn)
        (mode == pmc_pkg::MODE_ACTIVE && !busy) |->
            (ctl.pll_bypass && ctl.core_clk_en && ctl.sys_clk_en && ctl.l1_dma_allow))
        else $error("active outputs wrong");

    chk_mult_held: assert property (@(posedge ref_clk) disable iff (!rstn)
        (mode == pmc_pkg::MODE_ACTIVE && !(req_valid && req_mode == pmc_pkg::MODE_FULL_ON))
            |=> $stable(core_mult))
        else $error("multiplier changed outside full-on entry");

    chk_sleep_clocks: assert property (@(posedge ref_clk) disable iff (!rstn)
        (mode == pmc_pkg::MODE_SLEEP && !busy) |->
            (!ctl.core_clk_en && ctl.sys_clk_en && ctl.pll_enable && !ctl.l1_dma_allow))
        else $error("sleep outputs wrong");

    chk_sleep_wake: assert property (@(posedge ref_clk) disable iff (!rstn)
        (mode == pmc_pkg::MODE_SLEEP && !busy && wake_sleep) |=>
            (mode == ($past(byp_bit) ? pmc_pkg::MODE_ACTIVE : pmc_pkg::MODE_FULL_ON)))
        else $error("sleep wake went to wrong mode");

    chk_deep_rtc: assert property (@(posedge ref_clk) disable iff (!rstn)
        (mode == pmc_pkg::MODE_DEEP && !busy && s_rtc) |=>
            (mode == pmc_pkg::MODE_ACTIVE) ##1 busy ##20 busy ##[1:3] !busy)
        else $error("deep sleep alarm exit wrong");

    chk_hiber_entry: assert property (@(posedge ref_clk) disable iff (!rstn)
        (run_mode && !busy && regulator_frequency_field == pmc_pkg::REGULATOR_FREQUENCY_FIELD_OFF) |=>
            (mode == pmc_pkg::MODE_HIBER) ##[20:24] (!ctl.core_power && !ctl.sys_clk_en))
        else $error("hibernate entry wrong");

    chk_hiber_wake: assert property (@(posedge ref_clk) disable iff (!rstn)
        (mode == pmc_pkg::MODE_HIBER && !busy && s_act && wake_en[0]) |=>
            (mode == pmc_pkg::MODE_FULL_ON && regulator_frequency_field == pmc_pkg::REGULATOR_FREQUENCY_FIELD_RST))
        else $error("network activity did not leave hibernate");

    chk_safe_switch: assert property (@(posedge ref_clk) disable iff (!rstn)
        ($changed(ctl.pll_bypass) || $changed(ctl.pll_enable)) |->
            (!ctl.core_clk_en && !ctl.sys_clk_en && !$past(ctl.core_clk_en)))
        else $error("PLL changed while clocks ran");

endmodule

// ---- bench/pmc_power_mode_controller_tb_top.sv ----
// Self-checking testbench of the power mode controller driven over its register port.
module pmc_power_mode_controller_tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    logic                  ref_clk;
    logic                  rstn;
    pmc_pkg::pmc_bus_req_s bus;
    logic [15:0]           rdata;
    logic [15:0]           periph_clk_en;
    logic [15:0]           rv;
    logic [5:0]            core_mult;
    logic [3:0]            core_voltage_sel;
    logic [4:0]            wk;
    pmc_pkg::pmc_ctl_s     ctl;
    pmc_pkg::pmc_mode_e    mode;
    int                    bad_count;
    int                    checks_done;
    int                    cycles = 0;
    pmc_power_mode_controller u_dut (.ref_clk(ref_clk), .rstn(rstn), .bus(bus), .rdata(rdata),
        .ext_wake(wk[4]), .rtc_wake(wk[3]), .xcvr_preamble(wk[0]), .xcvr_irq(wk[1]),
        .xcvr_activity(wk[2]), .ctl(ctl), .core_mult(core_mult),
        .core_voltage_sel(core_voltage_sel), .periph_clk_en(periph_clk_en), .mode(mode));
    // ****************************************************************
    // Tasks
    // ****************************************************************
    task automatic cmp_v(input logic [15:0] got, input logic [15:0] exp, input string what);
        checks_done++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge ref_clk) bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge ref_clk) bus <= '0;
    endtask
    task automatic rd(input logic [3:0] a);
        @(posedge ref_clk) bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
        @(posedge ref_clk) bus <= '0;
        #1 rv = rdata;
    endtask
    task automatic wait_idle();
        int n;
        n = 0;
        do begin
            rd(pmc_pkg::OFS_STATUS);
            n++;
        end while (rv[5] !== 1'b0 && n < 60);
        cmp_v(16'(n < 60), 16'h0001, "sequencer idle");
    endtask
    task automatic go();
        wr(pmc_pkg::OFS_MODE_GO, 16'h0000);
        repeat (2) @(posedge ref_clk);
        wait_idle();
    endtask
    task automatic wake(input int i);
        @(posedge ref_clk) wk <= 5'h01 << i;
        repeat (4) @(posedge ref_clk);
        wait_idle();
        @(posedge ref_clk) wk <= 5'h00;
    endtask
    // ****************************************************************
    // Clock and timeout
    // ****************************************************************
    initial begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == 6000) begin
            bad_count++;
            give_verdict();
        end
    end
    // ****************************************************************
    // Scenarios
    // ****************************************************************
    initial begin
        rstn = 1'b0;
        bus = '0;
        wk = 5'h00;
        bad_count = 0;
        checks_done = 0;
        repeat (3) @(posedge ref_clk);
        rstn <= 1'b1;
        #1 cmp_v(16'(mode), 16'h0001, "reset mode");
        cmp_v(16'(ctl), 16'h002F, "reset controls");
        rd(pmc_pkg::OFS_STATUS);
        cmp_v(rv, 16'h0281, "status");
        rd(pmc_pkg::OFS_PLL_CTRL);
        cmp_v(rv, 16'h00A0, "pll control reset");
        rd(pmc_pkg::OFS_REG_CTRL);
        cmp_v(rv, 16'h0783, "regulator control reset");
        rd(4'hF);
        cmp_v(rv, 16'h0000, "unmapped read");
        wr(pmc_pkg::OFS_PERIPH_CLK, 16'h1234);
        #1 cmp_v(periph_clk_en, 16'h1234, "peripheral gates");
        wr(pmc_pkg::OFS_PLL_CTRL, 16'h00A2);
        go();
        cmp_v(16'(mode), 16'h0002, "active mode");
        cmp_v(16'(ctl), 16'h003F, "active controls");
        wr(pmc_pkg::OFS_PLL_CTRL, 16'h00A3);
        go();
        cmp_v(16'(ctl), 16'h001F, "pll off in active");
        wr(pmc_pkg::OFS_PLL_CTRL, 16'h00A2);
        go();
        cmp_v(16'(ctl), 16'h003F, "pll back on in active");
        wr(pmc_pkg::OFS_PLL_CTRL, 16'h0152);
        #1 cmp_v(16'(core_mult), 16'h000A, "multiplier held");
        wr(pmc_pkg::OFS_PLL_CTRL, 16'h0150);
        go();
        cmp_v(16'(core_mult), 16'h0015, "multiplier applied");
        cmp_v(16'(ctl), 16'h002F, "full-on controls");
        for (int i = 0; i < 6; i++) begin
            wr(pmc_pkg::OFS_PLL_CTRL, (i == 5) ? 16'h0156 : 16'h0154);
            go();
            cmp_v(16'(mode), 16'h0004, "sleep mode");
            cmp_v(16'(ctl), {10'h000, 1'b1, i == 5, 4'b0110}, "sleep controls");
            wake((i == 5) ? 4 : i);
            cmp_v(16'(mode), (i == 5) ? 16'h0002 : 16'h0001, "sleep exit");
        end
        wr(pmc_pkg::OFS_PLL_CTRL, 16'h0158);
        go();
        cmp_v(16'(mode), 16'h0008, "deep sleep");
        cmp_v(16'({ctl.pll_enable, ctl.core_clk_en, ctl.sys_clk_en}), 16'h0000, "deep");
        wake(3);
        cmp_v(16'(mode), 16'h0002, "deep sleep exit");
        wr(pmc_pkg::OFS_REG_CTRL, 16'h0750);
        #1 cmp_v(16'(core_voltage_sel), 16'h0005, "core voltage");
        repeat (2) @(posedge ref_clk);
        wait_idle();
        cmp_v(16'(mode), 16'h0010, "hibernate");
        cmp_v(16'({ctl.core_power, ctl.core_clk_en, ctl.sys_clk_en}), 16'h0000, "off");
        wake(2);
        cmp_v(16'(mode), 16'h0001, "hibernate exit");
        cmp_v(16'(ctl.core_power), 16'h0001, "regulator restored");
        rd(pmc_pkg::OFS_REG_CTRL);
        cmp_v(rv, 16'h0753, "regulator frequency restored");
        wr(pmc_pkg::OFS_PLL_CTRL, 16'h0158);
        go();
        cmp_v(16'(mode), 16'h0008, "deep sleep again");
        @(posedge ref_clk) rstn <= 1'b0;
        @(posedge ref_clk) rstn <= 1'b1;
        #1 cmp_v(16'(mode), 16'h0001, "reset leaves deep sleep");
        cmp_v(16'(ctl), 16'h002F, "reset controls again");
        give_verdict();
    end
endmodule
